// ===== rtl/slave_address_match.sv
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "addr_match_defines.svh"

// Summary of operation
// - Match first frame upper bits to primary address
// - Second address recognised only when enabled
// - Third address recognised only when enabled
// - Mask bit one forces that bit matching
// - Masking affects primary address only
// - Read bit sets direction and empty flags
// - Switch mask one leaves both flags alone
// - Second address hit in receive mode sets bit 7 flag
// - Third address hit in receive mode sets bit 6 flag
// - Flag clears by writing 0 after reading 1
// - Status bits 5 to 0 read zero
// - All five registers reset to zero

module slave_address_match
  import addr_match_pkg::*;
(
  input wire logic mclk, // System clock, 25 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic [4:0] avs_address, // Avalon byte address
  input wire logic avs_read, // Avalon read request
  input wire logic avs_write, // Avalon write request
  input wire logic [31:0] avs_writedata, // Avalon write data
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest, // Avalon wait, high stalls
  input wire logic scl_pin, // Serial clock pin level
  input wire logic sda_pin, // Serial data pin level
  input wire logic slave_mode, // Engine is in slave mode
  input wire logic clear_transmit_direction, // Engine clears direction
  input wire logic clear_transmit_empty, // Engine clears empty flag
  output logic addressed, // Device selected since last frame
  output logic address_match_pulse, // One cycle on any hit
  output logic transmit_direction_bit, // Slave transmit mode
  output logic transmit_empty_flag // Transmit buffer empty
);

  // ------------------------------------------------------------
  // First frame from the bus
  // ------------------------------------------------------------
  logic [7:0] frame_byte;
  logic frame_valid;
  logic frame_stop;

  first_frame_capture u_capture (
    .mclk(mclk),
    .nrst(nrst),
    .scl_pin(scl_pin),
    .sda_pin(sda_pin),
    .frame_byte(frame_byte),
    .frame_valid(frame_valid),
    .frame_stop(frame_stop)
  );

  // ------------------------------------------------------------
  // Register bus slave
  // ------------------------------------------------------------
  logic ack;
  logic next_ack;
  logic rd_take;
  logic wr_take;
  logic [31:0] next_readdata;
  logic [7:0] primary_own_address;
  logic [7:0] second_own_address;
  logic [7:0] third_own_address;
  logic [7:0] address_mask_control;
  logic [7:0] next_primary;
  logic [7:0] next_second;
  logic [7:0] next_third;
  logic [7:0] next_mask;
  logic second_match_flag;
  logic third_match_flag;
  logic [7:0] address_match_status;

  // Every access costs one wait cycle so read data can come from a flop
  assign next_ack = (avs_read | avs_write) & ~ack;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign rd_take = avs_read & ack;
  assign wr_take = avs_write & ack;

  assign address_match_status = {second_match_flag, third_match_flag, 6'h00};

  always_comb begin
    next_readdata = avs_readdata;
    if ((avs_read | avs_write) & ~ack) begin
      case (avs_address)
        `OFS_PRIMARY_OWN_ADDRESS: next_readdata = {24'h000000, primary_own_address};
        `OFS_SECOND_OWN_ADDRESS: next_readdata = {24'h000000, second_own_address};
        `OFS_THIRD_OWN_ADDRESS: next_readdata = {24'h000000, third_own_address};
        `OFS_ADDRESS_MASK_CONTROL: next_readdata = {24'h000000, address_mask_control};
        `OFS_ADDRESS_MATCH_STATUS: next_readdata = {24'h000000, address_match_status};
        default: next_readdata = 32'h00000000;
      endcase
    end
  end

  always_comb begin
    next_primary = primary_own_address;
    next_second = second_own_address;
    next_third = third_own_address;
    next_mask = address_mask_control;
    if (wr_take) begin
      case (avs_address)
        // Bit 0 is plain storage; software keeps it at zero
        `OFS_PRIMARY_OWN_ADDRESS: next_primary = avs_writedata[7:0];
        `OFS_SECOND_OWN_ADDRESS: next_second = avs_writedata[7:0];
        `OFS_THIRD_OWN_ADDRESS: next_third = avs_writedata[7:0];
        `OFS_ADDRESS_MASK_CONTROL: next_mask = avs_writedata[7:0];
        default: next_mask = address_mask_control;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ack <= 1'b0;
      avs_readdata <= 32'h00000000;
      primary_own_address <= `RST_OWN_ADDRESS;
      second_own_address <= `RST_OWN_ADDRESS;
      third_own_address <= `RST_OWN_ADDRESS;
      address_mask_control <= `RST_MASK_CONTROL;
    end else begin
      ack <= next_ack;
      avs_readdata <= next_readdata;
      primary_own_address <= next_primary;
      second_own_address <= next_second;
      third_own_address <= next_third;
      address_mask_control <= next_mask;
    end
  end

  // ------------------------------------------------------------
  // Address comparison
  // ------------------------------------------------------------
  logic [7:1] bit_ok;
  logic primary_hit;
  logic second_hit;
  logic third_hit;
  logic any_hit;
  logic rx_mode;

  genvar gi;
  generate
    for (gi = 1; gi < 8; gi = gi + 1) begin : g_mask
      assign bit_ok[gi] = address_mask_control[gi] |
                          (primary_own_address[gi] == frame_byte[gi]);
    end
  endgenerate

  // Unique own addresses keep two slaves from answering one frame
  assign primary_hit = &bit_ok;
  // The extra addresses compare exactly, the mask does not reach them
  assign second_hit = second_own_address[`BIT_EXTRA_ADDRESS_ENABLE] &
                      (second_own_address[7:1] == frame_byte[7:1]);
  assign third_hit = third_own_address[`BIT_EXTRA_ADDRESS_ENABLE] &
                     (third_own_address[7:1] == frame_byte[7:1]);
  assign any_hit = frame_valid & slave_mode &
                   (primary_hit | second_hit | third_hit);
  assign rx_mode = slave_mode & ~transmit_direction_bit;

  // ------------------------------------------------------------
  // Match state and recognition flags
  // ------------------------------------------------------------
  logic armed_second;
  logic armed_third;
  logic next_armed_second;
  logic next_armed_third;
  logic next_second_flag;
  logic next_third_flag;
  logic next_addressed;
  logic next_tx_dir;
  logic next_tx_empty;
  logic status_rd;
  logic status_wr;

  assign status_rd = rd_take & (avs_address == `OFS_ADDRESS_MATCH_STATUS);
  assign status_wr = wr_take & (avs_address == `OFS_ADDRESS_MATCH_STATUS);

  always_comb begin
    next_armed_second = armed_second;
    next_armed_third = armed_third;
    next_second_flag = second_match_flag;
    next_third_flag = third_match_flag;
    // Arm on the value software actually saw, not a later set
    if (status_rd & avs_readdata[`BIT_SECOND_MATCH_FLAG]) begin
      next_armed_second = 1'b1;
    end
    if (status_rd & avs_readdata[`BIT_THIRD_MATCH_FLAG]) begin
      next_armed_third = 1'b1;
    end
    if (status_wr & armed_second & ~avs_writedata[`BIT_SECOND_MATCH_FLAG]) begin
      next_second_flag = 1'b0;
      next_armed_second = 1'b0;
    end
    if (status_wr & armed_third & ~avs_writedata[`BIT_THIRD_MATCH_FLAG]) begin
      next_third_flag = 1'b0;
      next_armed_third = 1'b0;
    end
    // A new hit wins over a clear in the same cycle
    if (frame_valid & rx_mode & second_hit) begin
      next_second_flag = 1'b1;
    end
    if (frame_valid & rx_mode & third_hit) begin
      next_third_flag = 1'b1;
    end
  end

  always_comb begin
    next_addressed = addressed;
    next_tx_dir = transmit_direction_bit;
    next_tx_empty = transmit_empty_flag;
    if (frame_valid | frame_stop) begin
      next_addressed = 1'b0;
    end
    if (clear_transmit_direction) begin
      next_tx_dir = 1'b0;
    end
    if (clear_transmit_empty) begin
      next_tx_empty = 1'b0;
    end
    if (any_hit) begin
      next_addressed = 1'b1;
      if (~address_mask_control[`BIT_TRANSMIT_SWITCH_MASK] &
          frame_byte[`BIT_READ_DIRECTION]) begin
        next_tx_dir = 1'b1;
        next_tx_empty = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      armed_second <= 1'b0;
      armed_third <= 1'b0;
      second_match_flag <= `RST_MATCH_FLAG;
      third_match_flag <= `RST_MATCH_FLAG;
      addressed <= 1'b0;
      address_match_pulse <= 1'b0;
      transmit_direction_bit <= 1'b0;
      transmit_empty_flag <= 1'b0;
    end else begin
      armed_second <= next_armed_second;
      armed_third <= next_armed_third;
      second_match_flag <= next_second_flag;
      third_match_flag <= next_third_flag;
      addressed <= next_addressed;
      address_match_pulse <= any_hit;
      transmit_direction_bit <= next_tx_dir;
      transmit_empty_flag <= next_tx_empty;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_masked_primary;
    frame_valid && slave_mode &&
    (((frame_byte[7:1] ^ primary_own_address[7:1]) & ~address_mask_control[7:1]) == 7'h00);
  endsequence

  sequence s_no_hit;
    frame_valid && slave_mode &&
    (((frame_byte[7:1] ^ primary_own_address[7:1]) & ~address_mask_control[7:1]) != 7'h00) &&
    !(second_own_address[0] && second_own_address[7:1] == frame_byte[7:1]) &&
    !(third_own_address[0] && third_own_address[7:1] == frame_byte[7:1]);
  endsequence

  sequence s_status_clear_second;
    wr_take && avs_address == `OFS_ADDRESS_MATCH_STATUS &&
    !avs_writedata[7] && armed_second && !(frame_valid && rx_mode && second_hit);
  endsequence

  AST_PRIMARY_MATCH: assert property (@(posedge mclk) disable iff (!nrst)
    s_masked_primary |=> addressed && address_match_pulse)
    else $error("masked primary address hit not answered");

  AST_NO_MATCH: assert property (@(posedge mclk) disable iff (!nrst)
    s_no_hit |=> !address_match_pulse && !addressed)
    else $error("device answered a frame that matches no address");

  AST_SECOND_CAUSE: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(second_match_flag) |-> $past(frame_valid) && $past(second_own_address[0]) &&
    $past(second_own_address[7:1]) == $past(frame_byte[7:1]) && $past(rx_mode))
    else $error("second flag set without an enabled exact hit");

  AST_THIRD_CAUSE: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(third_match_flag) |-> $past(frame_valid) && $past(third_own_address[0]) &&
    $past(third_own_address[7:1]) == $past(frame_byte[7:1]) && $past(rx_mode))
    else $error("third flag set without an enabled exact hit");

  AST_SECOND_SET: assert property (@(posedge mclk) disable iff (!nrst)
    frame_valid && rx_mode && second_own_address[0] &&
    second_own_address[7:1] == frame_byte[7:1] |=> second_match_flag && addressed)
    else $error("second address hit did not set its flag");

  AST_THIRD_SET: assert property (@(posedge mclk) disable iff (!nrst)
    frame_valid && rx_mode && third_own_address[0] &&
    third_own_address[7:1] == frame_byte[7:1] |=> third_match_flag && addressed)
    else $error("third address hit did not set its flag");

  AST_AUTO_TRANSMIT: assert property (@(posedge mclk) disable iff (!nrst)
    s_masked_primary ##0 (!address_mask_control[0] && frame_byte[0])
    |=> transmit_direction_bit && transmit_empty_flag)
    else $error("read frame did not switch to slave transmit");

  AST_SWITCH_MASKED: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(transmit_direction_bit) |-> !$past(address_mask_control[0]) && $past(frame_byte[0]))
    else $error("direction bit set while switch was masked");

  AST_FLAG_CLEAR: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(second_match_flag) |-> $past(status_wr) && $past(armed_second) &&
    !$past(avs_writedata[7]))
    else $error("second flag cleared without read-one then write-zero");

  AST_CLEAR_TAKES: assert property (@(posedge mclk) disable iff (!nrst)
    s_status_clear_second |=> !second_match_flag)
    else $error("armed write of zero left second flag set");

  AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (!nrst)
    rd_take && avs_address == `OFS_ADDRESS_MATCH_STATUS |-> avs_readdata[5:0] == 6'h00)
    else $error("reserved status bits read nonzero");

  AST_BUS_ANSWER: assert property (@(posedge mclk) disable iff (!nrst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered after one wait cycle");

endmodule // slave_address_match

// ===== common/addr_match_defines.svh
`ifndef ADDR_MATCH_DEFINES_SVH
`define ADDR_MATCH_DEFINES_SVH

// Register byte offsets on the Avalon-MM slave
`define OFS_PRIMARY_OWN_ADDRESS 5'h00
`define OFS_SECOND_OWN_ADDRESS 5'h04
`define OFS_THIRD_OWN_ADDRESS 5'h08
`define OFS_ADDRESS_MASK_CONTROL 5'h0c
`define OFS_ADDRESS_MATCH_STATUS 5'h10

// Field positions
`define BIT_EXTRA_ADDRESS_ENABLE 0
`define BIT_TRANSMIT_SWITCH_MASK 0
`define BIT_SECOND_MATCH_FLAG 7
`define BIT_THIRD_MATCH_FLAG 6
`define BIT_READ_DIRECTION 0

// Reset values
`define RST_OWN_ADDRESS 8'h00
`define RST_MASK_CONTROL 8'h00
`define RST_MATCH_FLAG 1'b0

// Bits in the first frame after a start condition
`define FRAME_BITS 4'h8

`endif

// ===== common/addr_match_pkg.sv
package addr_match_pkg;

  typedef enum logic [1:0] {
    FR_IDLE,
    FR_SHIFT,
    FR_WAIT
  } frame_state_t;

endpackage

// ===== rtl/first_frame_capture.sv
`timescale 1ns/1ns
`include "addr_match_defines.svh"

module first_frame_capture
  import addr_match_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic scl_pin, // Serial clock from the bus
  input wire logic sda_pin, // Serial data from the bus
  output logic [7:0] frame_byte, // First frame after start
  output logic frame_valid, // One-cycle pulse, frame_byte ready
  output logic frame_stop // One-cycle pulse on stop condition
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic [1:0] line_d;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic start_det;
  logic stop_det;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync_a <= 2'h3;
      sync_b <= 2'h3;
      line_d <= 2'h3;
    end else begin
      sync_a <= {scl_pin, sda_pin};
      sync_b <= sync_a;
      line_d <= sync_b;
    end
  end

  assign scl_s = sync_b[1];
  assign sda_s = sync_b[0];
  assign scl_rise = scl_s & ~line_d[1];
  // Both conditions need SCL high before and after the SDA edge
  assign start_det = scl_s & line_d[1] & ~sda_s & line_d[0];
  assign stop_det = scl_s & line_d[1] & sda_s & ~line_d[0];

  // ------------------------------------------------------------
  // First-frame shifter
  // ------------------------------------------------------------
  frame_state_t state;
  frame_state_t next_state;
  logic [3:0] count;
  logic [3:0] next_count;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [7:0] next_frame_byte;
  logic next_frame_valid;

  always_comb begin
    next_state = state;
    next_count = count;
    next_shift = shift;
    next_frame_byte = frame_byte;
    next_frame_valid = 1'b0;
    case (state)
      FR_IDLE: begin
      end
      FR_SHIFT: begin
        if (scl_rise) begin
          next_shift = {shift[6:0], sda_s};
          next_count = count + 4'h1;
          if (count == `FRAME_BITS - 4'h1) begin
            next_frame_byte = {shift[6:0], sda_s};
            next_frame_valid = 1'b1;
            // Later frames belong to the protocol engine
            next_state = FR_WAIT;
          end
        end
      end
      FR_WAIT: begin
      end
      default: next_state = FR_IDLE;
    endcase
    if (stop_det) begin
      next_state = FR_IDLE;
    end
    // A repeated start opens a new first frame
    if (start_det) begin
      next_state = FR_SHIFT;
      next_count = 4'h0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= FR_IDLE;
      count <= 4'h0;
      shift <= 8'h00;
      frame_byte <= 8'h00;
      frame_valid <= 1'b0;
      frame_stop <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      shift <= next_shift;
      frame_byte <= next_frame_byte;
      frame_valid <= next_frame_valid;
      frame_stop <= stop_det;
    end
  end

endmodule // first_frame_capture

// ===== verification/two_wire_master_model.sv
`timescale 1ns/1ns

module two_wire_master_model (
  output logic scl, // Serial clock, stands high between frames
  output logic sda // Serial data, pull-up level when released
);
  // ----------------------------------------------------------------
  // Idle bus: both lines float up to the pull-up level
  // ----------------------------------------------------------------
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // ----------------------------------------------------------------
  // Frame pieces, 320 ns clock period
  // ----------------------------------------------------------------
  // Also serves as repeated start when called with the clock low
  task automatic start_cond();
    #40 sda = 1'b1;
    #40 scl = 1'b1;
    #80 sda = 1'b0;
    #80 scl = 1'b0;
  endtask

  // Eight bits, most significant first, then a released slot for the ack
  task automatic put_byte(input logic [7:0] b);
    logic [8:0] s;
    s = {b, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      #40 sda = s[i];
      #120 scl = 1'b1;
      #160 scl = 1'b0;
    end
  endtask

  task automatic stop_cond();
    #40 sda = 1'b0;
    #120 scl = 1'b1;
    #160 sda = 1'b1;
    #160;
  endtask
endmodule // two_wire_master_model

// ===== verification/tb_i2c_slave_address_match.sv
`timescale 1ns/1ns
`include "addr_match_defines.svh"

module tb_i2c_slave_address_match
  import addr_match_pkg::*;
;
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] thr;
    logic [7:0] msk;
    logic sm;
    logic [7:0] frm;
    logic hit;
    logic [7:0] st;
    logic dir;
  } row_t;

  logic mclk;
  logic nrst;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic scl_pin;
  logic sda_pin;
  logic slave_mode;
  logic clear_transmit_direction;
  logic clear_transmit_empty;
  logic addressed;
  logic address_match_pulse;
  logic transmit_direction_bit;
  logic transmit_empty_flag;
  int err_count;
  int cmp_count;
  int cycles;
  int hits;

  // Primary 0x5a, second 0x33, third 0x4c: all distinct on the bus
  row_t rows [12] = '{
    '{8'h67, 8'h99, 8'h00, 1'b1, 8'hb4, 1'b1, 8'h00, 1'b0},
    '{8'h67, 8'h99, 8'h00, 1'b1, 8'hb6, 1'b0, 8'h00, 1'b0},
    '{8'h67, 8'h99, 8'h02, 1'b1, 8'hb6, 1'b1, 8'h00, 1'b0},
    '{8'h67, 8'h99, 8'h00, 1'b1, 8'h66, 1'b1, 8'h80, 1'b0},
    '{8'h66, 8'h99, 8'h00, 1'b1, 8'h66, 1'b0, 8'h00, 1'b0},
    '{8'h67, 8'h99, 8'h00, 1'b1, 8'h98, 1'b1, 8'h40, 1'b0},
    '{8'h67, 8'h98, 8'h00, 1'b1, 8'h98, 1'b0, 8'h00, 1'b0},
    '{8'h67, 8'h99, 8'h02, 1'b1, 8'h64, 1'b0, 8'h00, 1'b0},
    '{8'h67, 8'h99, 8'h00, 1'b1, 8'hb5, 1'b1, 8'h00, 1'b1},
    '{8'h67, 8'h99, 8'h01, 1'b1, 8'hb5, 1'b1, 8'h00, 1'b0},
    '{8'h67, 8'h99, 8'h00, 1'b0, 8'hb4, 1'b0, 8'h00, 1'b0},
    '{8'h66, 8'h98, 8'hfe, 1'b1, 8'h02, 1'b1, 8'h00, 1'b0}
  };

  slave_address_match dut (
    .mclk(mclk),
    .nrst(nrst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .scl_pin(scl_pin),
    .sda_pin(sda_pin),
    .slave_mode(slave_mode),
    .clear_transmit_direction(clear_transmit_direction),
    .clear_transmit_empty(clear_transmit_empty),
    .addressed(addressed),
    .address_match_pulse(address_match_pulse),
    .transmit_direction_bit(transmit_direction_bit),
    .transmit_empty_flag(transmit_empty_flag)
  );

  two_wire_master_model master (
    .scl(scl_pin),
    .sda(sda_pin)
  );

  // ----------------------------------------------------------------
  // Clock, hit counter and hang guard
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (address_match_pulse === 1'b1) hits <= hits + 1;
    cycles <= cycles + 1;
    // About 1650 cycles expected; a stuck handshake ends here
    if (cycles == 12000) begin
      err_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Waitrequest is decoded from the ack flop and read data comes from a flop, so reading them as a rising edge
  // wakes us gives what that edge samples; only the hang guard ends a wait
  task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [7:0] d,
                          output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= ~wr;
    avs_write <= wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge mclk);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask

  task automatic bus_rd_check(input logic [4:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus_xfer(1'b0, a, 8'h00, q);
    check(q, {24'h0, exp});
  endtask

  // Start plus first frame; the caller issues the stop after its checks
  task automatic run_frame(input logic [7:0] f, output int nh);
    int h0;
    h0 = hits;
    // Pin moves land between rising edges, away from the sampling flops
    @(negedge mclk);
    master.start_cond();
    master.put_byte(f);
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    nh = hits - h0;
  endtask

  task automatic pulse_clears();
    @(posedge mclk);
    clear_transmit_direction <= 1'b1;
    clear_transmit_empty <= 1'b1;
    @(posedge mclk);
    clear_transmit_direction <= 1'b0;
    clear_transmit_empty <= 1'b0;
  endtask

  task automatic all_regs_zero();
    for (int k = 0; k < 5; k++) begin
      bus_rd_check(5'(k * 4), 8'h00);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int nh;
    nrst = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    slave_mode = 1'b1;
    clear_transmit_direction = 1'b0;
    clear_transmit_empty = 1'b0;
    err_count = 0;
    cmp_count = 0;
    cycles = 0;
    hits = 0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    all_regs_zero();
    for (int r = 0; r < 12; r++) begin
      slave_mode <= rows[r].sm;
      bus_wr(`OFS_PRIMARY_OWN_ADDRESS, 8'hb4);
      bus_wr(`OFS_SECOND_OWN_ADDRESS, rows[r].sec);
      bus_wr(`OFS_THIRD_OWN_ADDRESS, rows[r].thr);
      bus_wr(`OFS_ADDRESS_MASK_CONTROL, rows[r].msk);
      run_frame(rows[r].frm, nh);
      check(nh, rows[r].hit);
      check(addressed, rows[r].hit);
      check(transmit_direction_bit, rows[r].dir);
      check(transmit_empty_flag, rows[r].dir);
      master.stop_cond();
      bus_rd_check(`OFS_ADDRESS_MATCH_STATUS, rows[r].st);
      bus_wr(`OFS_ADDRESS_MATCH_STATUS, 8'h00);
      pulse_clears();
    end
    // A zero written before the flag was read as one must not clear it
    slave_mode <= 1'b1;
    bus_wr(`OFS_SECOND_OWN_ADDRESS, 8'h67);
    bus_wr(`OFS_ADDRESS_MASK_CONTROL, 8'h00);
    run_frame(8'h66, nh);
    master.stop_cond();
    bus_wr(`OFS_ADDRESS_MATCH_STATUS, 8'h00);
    bus_rd_check(`OFS_ADDRESS_MATCH_STATUS, 8'h80);
    bus_wr(`OFS_ADDRESS_MATCH_STATUS, 8'h00);
    bus_rd_check(`OFS_ADDRESS_MATCH_STATUS, 8'h00);
    // Unmapped place reads zero and ignores writes
    bus_wr(5'h14, 8'hff);
    bus_rd_check(5'h14, 8'h00);
    bus_rd_check(`OFS_PRIMARY_OWN_ADDRESS, 8'hb4);
    // Reset after the first frame, before the stop, while the device is selected
    run_frame(8'hb5, nh);
    check(addressed, 1'b1);
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    check(addressed, 1'b0);
    check(transmit_direction_bit, 1'b0);
    check(transmit_empty_flag, 1'b0);
    master.stop_cond();
    @(posedge mclk);
    nrst <= 1'b1;
    all_regs_zero();
    report_and_stop();
  end
endmodule // tb_i2c_slave_address_match
